// *** common/chan_irq_pkg.sv ***
// Constants and types shared by the channel interrupt logic.
// Assumes APB with 32-bit data; one register per aligned word.
package chan_irq_pkg;
  // Register byte offsets
  localparam logic [11:0] CMD_OFF  = 12'h000;
  localparam logic [11:0] RIC_OFF  = 12'h004;
  localparam logic [11:0] VEC_OFF  = 12'h008;
  localparam logic [11:0] FTC_OFF  = 12'h00c;
  localparam logic [11:0] MIC_OFF  = 12'h010;
  localparam logic [11:0] MST_OFF  = 12'h014;
  localparam logic [11:0] SCS_OFF  = 12'h018;
  localparam logic [11:0] MVR_OFF  = 12'h01c;
  localparam logic [11:0] PND_OFF  = 12'h020;
  localparam logic [11:0] DAT_OFF  = 12'h024;
  // Field positions
  localparam int RIC_EXT_IE   = 0;
  localparam int RIC_TX_IE    = 1;
  localparam int RIC_PAR_SPC  = 2;
  localparam int RIC_MODE_LO  = 3;
  localparam int RIC_MODE_HI  = 4;
  localparam int FTC_THR      = 3;
  localparam int MIC_VIS      = 0;
  localparam int MIC_NV       = 1;
  localparam int MIC_DLC      = 2;
  localparam int MIC_MIE      = 3;
  localparam int MIC_STAT_HI  = 4;
  localparam int CMD_LO       = 3;
  localparam int CMD_HI       = 5;
  localparam int MST_RCA      = 0;
  localparam int MST_TBE      = 2;
  localparam int PND_EXT      = 3;
  localparam int PND_TX       = 4;
  localparam int PND_RX       = 5;
  // Reset values
  localparam logic [7:0] RIC_RST = 8'h00;
  localparam logic [7:0] VEC_RST = 8'h00;
  localparam logic [7:0] FTC_RST = 8'h00;
  localparam logic [7:0] MIC_RST = 8'h00;
  // Commands in command register bits 5..3
  localparam logic [2:0] CMD_RST_EXT = 3'h2;
  localparam logic [2:0] CMD_CH_RST  = 3'h3;
  localparam logic [2:0] CMD_ERR_RST = 3'h6;
  localparam logic [2:0] CMD_RST_IUS = 3'h7;
  // Sources in priority order, highest first
  localparam int SRC_RX  = 0;
  localparam int SRC_TX  = 1;
  localparam int SRC_EXT = 2;
  localparam int NSRC    = 3;
  // Receive FIFO
  localparam int          FIFO_DEPTH = 8;
  localparam logic [3:0]  FIFO_THR   = 4'h4;
  // Vector status codes
  localparam logic [1:0] CODE_TBE = 2'h0;
  localparam logic [1:0] CODE_EXT = 2'h1;
  localparam logic [1:0] CODE_RCA = 2'h2;
  localparam logic [1:0] CODE_SPC = 2'h3;
  typedef enum logic [1:0] {
    RX_OFF = 2'h0, RX_FIRST = 2'h1, RX_ALL = 2'h2, RX_SPC_ONLY = 2'h3
  } rx_mode_e;
  typedef struct packed {
    logic       eof;
    logic       framing;
    logic       parity;
    logic [7:0] data;
  } rx_entry_s;
endpackage

// *** design/irq_source_cell.sv ***
// Enable-gated pending flag and under-service flag of one source.
// Assumes grant and clear strobes are one-cycle pulses.
`timescale 1ns/1ps
module irq_source_cell (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic enable,
  input  wire logic set_evt,
  input  wire logic clr_evt,
  input  wire logic grant,
  input  wire logic ius_clr,
  input  wire logic soft_rst,
  output logic      pending_q,
  output logic      ius_q
);
  // Set wins over clear so that a coinciding event is not lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pending_q <= 1'b0;
    end else if (soft_rst) begin
      pending_q <= 1'b0;
    end else begin
      pending_q <= enable & (set_evt | (pending_q & ~clr_evt));
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ius_q <= 1'b0;
    end else if (grant) begin
      ius_q <= 1'b1;
    end else if (ius_clr || soft_rst) begin
      ius_q <= 1'b0;
    end
  end
endmodule

// *** design/rx_fifo.sv ***
// Eight-entry receive data FIFO with per-entry error status.
// Assumes push is refused by the caller while full.
`timescale 1ns/1ps
module rx_fifo import chan_irq_pkg::*; (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       push,
  input  wire rx_entry_s  wr_entry,
  input  wire logic       pop,
  input  wire logic       par_en,
  output rx_entry_s       head,
  output logic [3:0]      count,
  output logic            err_head,
  output logic            err_near
);
  rx_entry_s  mem_q [FIFO_DEPTH];
  logic [2:0] rd_q;
  logic [2:0] wr_q;
  logic [3:0] cnt_q;
  logic       do_pop;
  logic [2:0] idx;

  assign do_pop = pop & (cnt_q != 4'h0);
  assign count  = cnt_q;
  assign head   = mem_q[rd_q];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_q  <= 3'h0;
      wr_q  <= 3'h0;
      cnt_q <= 4'h0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 3'h1;
      end
      if (do_pop) begin
        rd_q <= rd_q + 3'h1;
      end
      cnt_q <= cnt_q + {3'h0, push} - {3'h0, do_pop};
    end
  end

  always_ff @(posedge pclk) begin
    if (push) begin
      mem_q[wr_q] <= wr_entry;
    end
  end

  // Errors among the four oldest entries flag a special condition early
  always_comb begin
    err_head = (cnt_q != 4'h0) & (head.eof | head.framing | (par_en & head.parity));
    err_near = 1'b0;
    idx      = rd_q;
    for (int i = 0; i < 4; i++) begin
      idx = rd_q + 3'(i);
      if (4'(i) < cnt_q) begin
        err_near = err_near | mem_q[idx].eof | mem_q[idx].framing | (par_en & mem_q[idx].parity);
      end
    end
  end
endmodule

// *** design/serial_channel_interrupt_daisy_chain.sv ***
// Interrupt control of one serial channel: sources, daisy chain, vector.
// Assumes an APB master, a receiver that pushes bytes, and a CPU that
// drives the acknowledge strobes synchronously to pclk.
//
// Functional notes
// - Request only with master enable, enabled pending, no higher service, chain in high, no ack.
// - Raising a request leaves priority out following priority in.
// - During acknowledge, any pending or in-service bit pulls priority out low.
// - On vector request the highest eligible pending source becomes in-service.
// - Vector driven on acknowledge read unless no-vector is set.
// - Vector unchanged without include-status; else two bits carry a source code.
// - Codes: 00 transmit empty, 01 external, 10 receive char, 11 special.
// - Status low uses bits 2..1; status high uses bit 5 then bit 6.
// - In-service bits clear only by reset-highest command, channel reset command or reset.
// - Disable-lower-chain forces priority out low.
// - Writing transmit data clears the transmit pending bit.
// - Receive control bits 4..3 pick mode; bit 2 makes parity special.
// - Overrun, framing, end of frame, enabled parity are special conditions.
// - Threshold off: one byte raises receive interrupt; seven more fit before overrun.
// - Threshold on: four bytes or a special condition raise receive interrupt.
// - Threshold on: four bytes left after reset-highest raise another interrupt.
// - Threshold on: error in four oldest entries raises special at once.
// - Status bit 0 shows at least one received byte regardless of threshold.
// - Receive interrupts disabled: no receive request, status still readable.
// - Reading receive data pops data and error status together.
// - Fixed internal priority: receiver, transmitter, external status.
// - Master enable at bit 3 of master control; zero suppresses all requests.
`timescale 1ns/1ps
module serial_channel_interrupt_daisy_chain import chan_irq_pkg::*; (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rx_push,
  input  wire rx_entry_s   rx_in,
  input  wire logic        tx_empty_evt,
  input  wire logic        tx_entry_empty,
  input  wire logic        ext_status_evt,
  input  wire logic        intack,
  input  wire logic        vector_request,
  input  wire logic        priority_in,
  output logic             int_req,
  output logic             priority_out,
  output logic      [7:0]  ack_data,
  output logic             ack_data_oe,
  output logic             tx_write,
  output logic      [7:0]  tx_data
);
  logic [7:0]      ric_q;
  logic [7:0]      vec_q;
  logic [7:0]      ftc_q;
  logic [7:0]      mic_q;
  logic            overrun_q;
  logic [31:0]     prdata_q;
  logic            pready_q;
  logic            pslverr_q;
  logic            pop_ok_q;
  logic            int_req_q;
  logic            pri_out_q;
  logic [7:0]      ack_data_q;
  logic            ack_oe_q;
  logic            tx_write_q;
  logic [7:0]      tx_data_q;
  logic [NSRC-1:0] pend;
  logic [NSRC-1:0] source_under_service;
  logic [NSRC-1:0] ie;
  logic [NSRC-1:0] set_v;
  logic [NSRC-1:0] clr_v;
  logic [NSRC-1:0] req_v;
  logic [NSRC-1:0] grant_v;
  logic [NSRC-1:0] iclr_v;
  logic            acc;
  logic            done;
  logic            wr_en;
  logic            addr_hit;
  logic [31:0]     rd_data;
  logic [2:0]      cmd;
  logic            cmd_ius;
  logic            cmd_err;
  logic            cmd_ext;
  logic            soft_rst;
  logic            dat_wr;
  logic            dat_rd;
  rx_mode_e        mode;
  logic            thr;
  rx_entry_s       head;
  logic [3:0]      count;
  logic            err_head;
  logic            err_near;
  logic            fifo_push;
  logic            avail;
  logic            special;
  logic            rx_cond;
  logic            hit;
  logic            blk;
  logic [1:0]      sel;
  logic [1:0]      code;
  logic            ack_evt;
  logic [7:0]      mvec;

  assign prdata       = prdata_q;
  assign pready       = pready_q;
  assign pslverr      = pslverr_q;
  assign int_req      = int_req_q;
  assign priority_out = pri_out_q;
  assign ack_data     = ack_data_q;
  assign ack_data_oe  = ack_oe_q;
  assign tx_write     = tx_write_q;
  assign tx_data      = tx_data_q;

  //////////////////////////////////////////////////////////////////////////////
  // APB slave: one wait state, so reads are captured before the pop

  assign acc      = psel & penable;
  assign done     = acc & pready_q;
  assign wr_en    = done & pwrite;
  assign cmd      = pwdata[CMD_HI:CMD_LO];
  assign cmd_ius  = wr_en & (paddr == CMD_OFF) & (cmd == CMD_RST_IUS);
  assign cmd_err  = wr_en & (paddr == CMD_OFF) & (cmd == CMD_ERR_RST);
  assign cmd_ext  = wr_en & (paddr == CMD_OFF) & (cmd == CMD_RST_EXT);
  assign soft_rst = wr_en & (paddr == CMD_OFF) & (cmd == CMD_CH_RST);
  assign dat_wr   = wr_en & (paddr == DAT_OFF);
  assign dat_rd   = done & ~pwrite & (paddr == DAT_OFF) & pop_ok_q;

  always_comb begin
    addr_hit = 1'b1;
    rd_data  = 32'h0;
    if (paddr == CMD_OFF) begin
      rd_data = 32'h0;
    end else if (paddr == RIC_OFF) begin
      rd_data[7:0] = ric_q;
    end else if (paddr == VEC_OFF) begin
      rd_data[7:0] = vec_q;
    end else if (paddr == FTC_OFF) begin
      rd_data[7:0] = ftc_q;
    end else if (paddr == MIC_OFF) begin
      rd_data[7:0] = mic_q;
    end else if (paddr == MST_OFF) begin
      rd_data[MST_RCA] = (count != 4'h0);
      rd_data[MST_TBE] = tx_entry_empty;
    end else if (paddr == SCS_OFF) begin
      rd_data[7:4] = {head.eof, head.framing, overrun_q, head.parity};
    end else if (paddr == MVR_OFF) begin
      rd_data[7:0] = mvec;
    end else if (paddr == PND_OFF) begin
      rd_data[PND_RX]  = pend[SRC_RX];
      rd_data[PND_TX]  = pend[SRC_TX];
      rd_data[PND_EXT] = pend[SRC_EXT];
    end else if (paddr == DAT_OFF) begin
      rd_data[7:0] = head.data;
    end else begin
      addr_hit = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h0;
      pslverr_q <= 1'b0;
      pop_ok_q  <= 1'b0;
    end else begin
      pready_q <= acc & ~pready_q;
      if (acc && !pready_q) begin
        prdata_q  <= pwrite ? 32'h0 : rd_data;
        pslverr_q <= ~addr_hit;
        pop_ok_q  <= (count != 4'h0);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ric_q <= RIC_RST;
      vec_q <= VEC_RST;
      ftc_q <= FTC_RST;
      mic_q <= MIC_RST;
    end else if (wr_en) begin
      if (paddr == RIC_OFF) begin
        ric_q <= pwdata[7:0];
      end else if (paddr == VEC_OFF) begin
        vec_q <= pwdata[7:0];
      end else if (paddr == FTC_OFF) begin
        ftc_q <= pwdata[7:0];
      end else if (paddr == MIC_OFF) begin
        mic_q <= pwdata[7:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_write_q <= 1'b0;
      tx_data_q  <= 8'h00;
    end else begin
      tx_write_q <= dat_wr;
      if (dat_wr) begin
        tx_data_q <= pwdata[7:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Receive FIFO and receive interrupt condition

  assign mode      = rx_mode_e'(ric_q[RIC_MODE_HI:RIC_MODE_LO]);
  assign thr       = ftc_q[FTC_THR];
  assign fifo_push = rx_push & (count != 4'(FIFO_DEPTH));

  rx_fifo u_rx_fifo (
    .pclk     (pclk),
    .presetn  (presetn),
    .push     (fifo_push),
    .wr_entry (rx_in),
    .pop      (dat_rd),
    .par_en   (ric_q[RIC_PAR_SPC]),
    .head     (head),
    .count    (count),
    .err_head (err_head),
    .err_near (err_near)
  );

  // Overrun stays until the error reset or channel reset command; set wins over either clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overrun_q <= 1'b0;
    end else if (rx_push && count == 4'(FIFO_DEPTH)) begin
      overrun_q <= 1'b1;
    end else if (cmd_err || soft_rst) begin
      overrun_q <= 1'b0;
    end
  end

  // Pending is a level: with four bytes still held it reasserts after service
  always_comb begin
    avail   = thr ? (count >= FIFO_THR) : (count != 4'h0);
    special = overrun_q | (thr ? err_near : err_head);
    rx_cond = (mode != RX_OFF) & (special | (avail & (mode == RX_FIRST || mode == RX_ALL)));
  end

  //////////////////////////////////////////////////////////////////////////////
  // Source cells

  assign ie[SRC_RX]     = (mode != RX_OFF);
  assign ie[SRC_TX]     = ric_q[RIC_TX_IE];
  assign ie[SRC_EXT]    = ric_q[RIC_EXT_IE];
  assign set_v[SRC_RX]  = rx_cond;
  assign clr_v[SRC_RX]  = ~rx_cond;
  assign set_v[SRC_TX]  = tx_empty_evt;
  assign clr_v[SRC_TX]  = dat_wr;
  assign set_v[SRC_EXT] = ext_status_evt;
  assign clr_v[SRC_EXT] = cmd_ext;

  for (genvar g = 0; g < NSRC; g++) begin : g_src
    irq_source_cell u_cell (
      .pclk      (pclk),
      .presetn   (presetn),
      .enable    (ie[g]),
      .set_evt   (set_v[g]),
      .clr_evt   (clr_v[g]),
      .grant     (grant_v[g]),
      .ius_clr   (iclr_v[g]),
      .soft_rst  (soft_rst),
      .pending_q (pend[g]),
      .ius_q     (source_under_service[g])
    );
  end

  //////////////////////////////////////////////////////////////////////////////
  // Internal daisy chain, acknowledge and vector

  assign ack_evt = intack & vector_request & priority_in & mic_q[MIC_MIE];

  always_comb begin
    blk     = 1'b0;
    hit     = 1'b0;
    sel     = 2'h0;
    req_v   = '0;
    grant_v = '0;
    iclr_v  = '0;
    for (int i = 0; i < NSRC; i++) begin
      req_v[i] = pend[i] & ie[i] & ~source_under_service[i] & ~blk;
      if (req_v[i] && !hit) begin
        sel = 2'(i);
      end
      if (source_under_service[i] && !blk) begin
        iclr_v[i] = cmd_ius;
      end
      hit = hit | req_v[i];
      blk = blk | source_under_service[i];
    end
    if (ack_evt && hit) begin
      grant_v[sel] = 1'b1;
    end
  end

  always_comb begin
    if (!hit) begin
      code = CODE_TBE;
    end else if (sel == 2'(SRC_RX)) begin
      code = special ? CODE_SPC : CODE_RCA;
    end else if (sel == 2'(SRC_TX)) begin
      code = CODE_TBE;
    end else begin
      code = CODE_EXT;
    end
    mvec = vec_q;
    if (mic_q[MIC_VIS] && mic_q[MIC_STAT_HI]) begin
      mvec[5] = code[1];
      mvec[6] = code[0];
    end else if (mic_q[MIC_VIS]) begin
      mvec[2:1] = code;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_req_q <= 1'b0;
      pri_out_q <= 1'b0;
    end else begin
      int_req_q <= mic_q[MIC_MIE] & hit & priority_in & ~intack;
      if (mic_q[MIC_DLC]) begin
        pri_out_q <= 1'b0;
      end else if (intack) begin
        pri_out_q <= priority_in & ~(|pend) & ~(|source_under_service);
      end else begin
        pri_out_q <= priority_in & ~(|source_under_service);
      end
    end
  end

  // Vector stays on the bus until the acknowledge ends
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_data_q <= 8'h00;
      ack_oe_q   <= 1'b0;
    end else if (!intack) begin
      ack_oe_q <= 1'b0;
    end else if (ack_evt && hit) begin
      ack_data_q <= mvec;
      ack_oe_q   <= ~mic_q[MIC_NV];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence ack_granted;
    intack && vector_request && priority_in && mic_q[MIC_MIE] && hit;
  endsequence

  req_cause_a: assert property (int_req_q |-> $past(mic_q[MIC_MIE] && priority_in && !intack && hit))
    else $error("request without its enabling conditions");
  ieo_mirror_a: assert property (presetn && !intack && !mic_q[MIC_DLC] && source_under_service == '0 |=>
    pri_out_q == $past(priority_in))
    else $error("priority out not following priority in");
  ieo_ack_a: assert property (intack && (pend != '0 || source_under_service != '0) |=> !pri_out_q)
    else $error("priority out high during acknowledge with pending");
  ius_grant_a: assert property (ack_granted |=> (source_under_service & $past(grant_v)) != '0)
    else $error("acknowledged source not under service");
  vec_drive_a: assert property (ack_granted |=>
    ack_oe_q == !mic_q[MIC_NV] && (!ack_oe_q || ack_data_q == $past(mvec)))
    else $error("vector drive wrong after acknowledge");
  vis_plain_a: assert property ((ack_granted and !mic_q[MIC_VIS]) |=> ack_data_q == $past(vec_q))
    else $error("vector modified without include-status");
  ius_hold_a: assert property ($fell(source_under_service[SRC_RX]) |-> $past(cmd_ius || soft_rst))
    else $error("under-service bit cleared without command");
  dlc_low_a: assert property (mic_q[MIC_DLC] |=> !pri_out_q)
    else $error("priority out high with lower chain disabled");
  tx_clear_a: assert property (dat_wr && !tx_empty_evt |=> !pend[SRC_TX])
    else $error("transmit pending survived a data write");
  rx_off_a: assert property (mode == RX_OFF |=> !pend[SRC_RX])
    else $error("receiver pending while receive interrupts disabled");
endmodule

// *** tb/cpu_ack_model.sv ***
// Host side of a hardware acknowledge cycle.
// Assumes the bench calls ack only while the device requests.
`timescale 1ns/1ps
module cpu_ack_model (
  input  wire logic       pclk,
  input  wire logic [7:0] ack_data,
  input  wire logic       ack_data_oe,
  input  wire logic       priority_out,
  output logic            intack,
  output logic            vector_request
);
  initial begin
    intack = 1'b0;
    vector_request = 1'b0;
  end
  // The chain gets two cycles to settle before the vector is asked for
  task automatic ack(output logic [7:0] v, output logic oe, output logic po);
    @(posedge pclk) intack <= 1'b1;
    @(posedge pclk);
    @(negedge pclk) po = priority_out;
    @(posedge pclk) vector_request <= 1'b1;
    @(posedge pclk) vector_request <= 1'b0;
    @(negedge pclk) v = ack_data;
    oe = ack_data_oe;
    @(posedge pclk) intack <= 1'b0;
  endtask
endmodule

// *** tb/tb_serial_channel_interrupt_daisy_chain.sv ***
// Self-checking bench for the channel interrupt logic.
// Assumes the APB slave answers in bounded time; reads are checked by a monitor.
`timescale 1ns/1ps
module tb_serial_channel_interrupt_daisy_chain import chan_irq_pkg::*; ;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        rx_push, tx_empty_evt, tx_entry_empty, ext_status_evt;
  logic        intack, vector_request, priority_in, int_req, priority_out;
  logic        ack_data_oe, tx_write, aoe, apo;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0]  ack_data, tx_data, v, av, t;
  logic [32:0] note;
  rx_entry_s   rx_in;
  int          miscompares, n_checks;
  logic [32:0] notes[$];
  logic [7:0]  b[$];
  ////////////////////////////////////////////////////////////////////////
  serial_channel_interrupt_daisy_chain uut (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .rx_push, .rx_in,
    .tx_empty_evt, .tx_entry_empty, .ext_status_evt, .intack, .vector_request,
    .priority_in, .int_req, .priority_out, .ack_data, .ack_data_oe, .tx_write, .tx_data);
  cpu_ack_model cpu (.pclk, .ack_data, .ack_data_oe, .priority_out, .intack, .vector_request);
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", nm, e, s);
    end
  endtask
  // Read data is judged where it appears, against the oldest note
  always @(negedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      note = notes.pop_front();
      chk("pslverr", pslverr, note[32]);
      if (!note[32])
        chk("prdata", prdata, note[31:0]);
    end
  end
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk) psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1'b1;
    do begin
      @(negedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      miscompares++;
      end_sim();
    end
    @(posedge pclk) psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(logic [11:0] a, logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(logic [11:0] a, logic [31:0] e);
    notes.push_back({1'b0, e});
    apb(1'b0, a, 32'h0);
  endtask
  task automatic push(logic [10:0] d);
    b.push_back(d[7:0]);
    @(posedge pclk) rx_push <= 1'b1;
    rx_in <= d;
    @(posedge pclk) rx_push <= 1'b0;
  endtask
  task automatic wreq(logic e);
    repeat (12) begin
      @(negedge pclk);
      if (int_req === e) break;
    end
    chk("int_req", int_req, e);
    if (int_req !== e) end_sim();
  endtask
  task automatic idle(logic e);
    repeat (8) @(negedge pclk);
    chk("int_req", int_req, e);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {presetn, psel, penable, pwrite, rx_push, tx_empty_evt, ext_status_evt} = 7'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    rx_in = 11'h0;
    priority_in = 1'b1;
    miscompares = 0;
    n_checks = 0;
    v = 8'($urandom(43312));
    v = 8'($urandom) & 8'h99;
    tx_entry_empty = 1'($urandom);
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd(RIC_OFF, 32'h0);
    rd(FTC_OFF, 32'h0);
    rd(MIC_OFF, 32'h0);
    rd(PND_OFF, 32'h0);
    notes.push_back({1'b1, 32'h0});
    apb(1'b0, 12'h030, 32'h0);
    $display("reset test done");
    wr(VEC_OFF, v);
    wr(RIC_OFF, 32'h13);
    wr(MIC_OFF, 32'h09);
    push(8'($urandom));
    wreq(1'b1);
    chk("prio_out", priority_out, 1'b1);
    rd(MST_OFF, {29'h0, tx_entry_empty, 2'h1});
    rd(PND_OFF, 32'h20);
    cpu.ack(av, aoe, apo);
    chk("vector", av, v | 8'h04);
    chk("vec_oe", aoe, 1'b1);
    chk("prio_ack", apo, 1'b0);
    idle(1'b0);
    rd(DAT_OFF, b.pop_front());
    wr(CMD_OFF, 32'h38);
    idle(1'b0);
    $display("receive test done");
    wr(MIC_OFF, 32'h19);
    @(posedge pclk) tx_empty_evt <= 1'b1;
    ext_status_evt <= 1'b1;
    @(posedge pclk) tx_empty_evt <= 1'b0;
    ext_status_evt <= 1'b0;
    wreq(1'b1);
    cpu.ack(av, aoe, apo);
    chk("vector", av, v);
    idle(1'b0);
    rd(PND_OFF, 32'h18);
    t = 8'($urandom);
    wr(DAT_OFF, t);
    repeat (4) begin
      @(negedge pclk);
      if (tx_write === 1'b1) break;
    end
    chk("tx_write", tx_write, 1'b1);
    chk("tx_data", tx_data, t);
    rd(PND_OFF, 32'h08);
    wr(CMD_OFF, 32'h38);
    wreq(1'b1);
    cpu.ack(av, aoe, apo);
    chk("vector", av, v | 8'h40);
    wr(CMD_OFF, 32'h10);
    wr(CMD_OFF, 32'h38);
    idle(1'b0);
    $display("priority test done");
    wr(MIC_OFF, 32'h0b);
    push(8'($urandom));
    wreq(1'b1);
    cpu.ack(av, aoe, apo);
    chk("vec_oe", aoe, 1'b0);
    rd(DAT_OFF, b.pop_front());
    wr(CMD_OFF, 32'h38);
    wr(MIC_OFF, 32'h0c);
    repeat (2) @(negedge pclk);
    chk("prio_out", priority_out, 1'b0);
    wr(MIC_OFF, 32'h00);
    push(8'($urandom));
    idle(1'b0);
    @(posedge pclk) priority_in <= 1'b0;
    wr(MIC_OFF, 32'h08);
    idle(1'b0);
    @(posedge pclk) priority_in <= 1'b1;
    wreq(1'b1);
    rd(DAT_OFF, b.pop_front());
    wreq(1'b0);
    wr(RIC_OFF, 32'h03);
    push(8'($urandom));
    idle(1'b0);
    rd(MST_OFF, {29'h0, tx_entry_empty, 2'h1});
    rd(DAT_OFF, b.pop_front());
    wr(RIC_OFF, 32'h13);
    $display("chain test done");
    wr(MIC_OFF, 32'h09);
    wr(FTC_OFF, 32'h08);
    repeat (3) push(8'($urandom));
    idle(1'b0);
    rd(MST_OFF, {29'h0, tx_entry_empty, 2'h1});
    repeat (2) push(8'($urandom));
    wreq(1'b1);
    cpu.ack(av, aoe, apo);
    chk("vector", av, v | 8'h04);
    rd(DAT_OFF, b.pop_front());
    wr(CMD_OFF, 32'h38);
    wreq(1'b1);
    cpu.ack(av, aoe, apo);
    repeat (4) rd(DAT_OFF, b.pop_front());
    wr(CMD_OFF, 32'h38);
    idle(1'b0);
    push({3'h2, 8'($urandom)});
    wreq(1'b1);
    cpu.ack(av, aoe, apo);
    chk("vector", av, v | 8'h06);
    rd(SCS_OFF, 32'h40);
    rd(DAT_OFF, b.pop_front());
    wr(CMD_OFF, 32'h38);
    idle(1'b0);
    wr(FTC_OFF, 32'h00);
    repeat (8) push(8'($urandom));
    rd(SCS_OFF, 32'h0);
    push(8'($urandom));
    rd(SCS_OFF, 32'h20);
    rd(MVR_OFF, {24'h0, v | 8'h06});
    wr(CMD_OFF, 32'h30);
    rd(SCS_OFF, 32'h0);
    rd(MVR_OFF, {24'h0, v | 8'h04});
    $display("threshold test done");
    end_sim();
  end
  initial begin
    repeat (60000) @(posedge pclk);
    miscompares++;
    end_sim();
  end
endmodule
